// File: shared/strap_cfg_pkg.sv
// Constants for the strap-driven configuration latch.
// Assumes a byte-wide register port with 8-bit offsets.
package strap_cfg_pkg;
    localparam logic [7:0] BRIDGE_CONTROL_OFFSET = 8'h4F;
    localparam logic [7:0] BRIDGE_CONFIG_OFFSET  = 8'h54;
    localparam logic [7:0] LINK_CONTROL_OFFSET   = 8'h5B;
    localparam logic [7:0] REMOTE_ID_ADDR_OFFSET = 8'h5C;

    localparam int DISPLAY_ID_DISABLE_POS  = 0;
    localparam int AUDIO_AUX_POS           = 1;
    localparam int REMOTE_ID_COPY_POS      = 5;
    localparam int EXTERNAL_CONTROL_POS    = 7;
    localparam int PLL_RESET_FREQ_POS      = 5;
    localparam int COAXIAL_MODE_POS        = 7;

    localparam logic [7:0] BRIDGE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] BRIDGE_CONFIG_RESET  = 8'h00;
    localparam logic [7:0] LINK_CONTROL_RESET   = 8'h20;
    localparam logic [7:0] REMOTE_ID_ADDR_RESET = 8'hA0;

    localparam int FIRST_LEVEL_WIDTH  = 2;
    localparam int SECOND_LEVEL_WIDTH = 3;

    localparam int PIXEL_CLOCK_MAX_MHZ     = 96;
    localparam int LEGACY_PIXEL_MAX_MHZ    = 85;
    localparam int PIXEL_COLOUR_BITS       = 24;

    typedef enum logic [2:0] {
        CAPTURE_WAIT = 3'b001,
        CAPTURE_TAKE = 3'b010,
        CAPTURE_DONE = 3'b100
    } capture_state_type;
endpackage

// File: core/strap_decoder.sv
// Decodes resolved strap level indices into the five mode settings.
// Assumes the level indices are already two-flop synchronised.
`timescale 1ns/10ps
module strap_decoder
    import strap_cfg_pkg::*;
(
    input  wire logic [FIRST_LEVEL_WIDTH-1:0]  strap_level_first_i,
    input  wire logic [SECOND_LEVEL_WIDTH-1:0] strap_level_second_i,
    output logic                               display_id_source_o,
    output logic                               aux_audio_o,
    output logic                               controller_override_o,
    output logic                               cable_is_coaxial_o,
    output logic                               remote_id_copy_o
);
    assign display_id_source_o   = strap_level_first_i[1]; // R3
    assign aux_audio_o           = strap_level_first_i[0]; // R3
    assign controller_override_o = strap_level_second_i[2]; // R4
    assign cable_is_coaxial_o    = strap_level_second_i[1]; // R4
    assign remote_id_copy_o      = strap_level_second_i[0]; // R4
endmodule // strap_decoder

// File: core/strap_mode_config_latch.sv
// Power-up strap capture into configuration registers, with software
// override and the mode outputs that the rest of the bridge obeys.
// Assumes a simple byte register port on clock_i; strap levels come
// from an analog resolver outside this clock domain.
`timescale 1ns/10ps

// Contract
// R1: Capture both decoded straps into register fields at power-up.
// R2: Software reads each captured field and may overwrite it later.
// R3: First strap's four levels give display-ID source and aux audio.
// R4: Second strap's index bits give override, coaxial, remote copy, MSB first.
// R5: Source 0 searches remote display-ID memory at 0xA0, else internal SRAM.
// R6: Source 1 selects the external local display-ID memory.
// R7: Aux audio 0 carries video audio only; 1 adds the aux channel.
// R8: Override 1 hands video input control to external I2C controller.
// R9: Coaxial bit selects coaxial or twisted-pair link configuration.
// R10: Remote copy 1 copies remote display-ID into SRAM when available.
// R11: Display-ID source lands in bit 0 of register 0x4F.
// R12: Aux audio lands in bit 1 of register 0x54.
// R13: Controller override lands in bit 7 of register 0x54.
// R14: Cable type lands in bit 7 of register 0x5B.
// R15: Remote copy lands in bit 5 of register 0x54.
// R16: Single link carries up to 96 MHz, 24-bit video.
// R17: System keeps pixel clock under 85 MHz for older receivers.
// R18: With PLL-reset feature on, frequency detect may reset the PLL.
// R19: Clearing 0x5B bit 5 stops PLL resets on frequency change.
// R20: Host writes PLL-reset disable after finishing all configuration.
// R21: Host reaches registers over I2C-compatible bus, one of eight addresses.
// R22: Sample strap indices once at reset release; hold until write.
// R23: Capture touches only the five strap bits; others keep reset values.
module strap_mode_config_latch
    import strap_cfg_pkg::*;
(
    input  wire logic                          clock_i,
    input  wire logic                          rst_i,
    input  wire logic [FIRST_LEVEL_WIDTH-1:0]  strap_level_first_i,
    input  wire logic [SECOND_LEVEL_WIDTH-1:0] strap_level_second_i,
    input  wire logic                          reg_write_i,
    input  wire logic                          reg_read_i,
    input  wire logic [7:0]                    reg_addr_i,
    input  wire logic [7:0]                    reg_wdata_i,
    output logic [7:0]                         reg_rdata_o,
    output logic                               reg_hit_o,
    input  wire logic                          freq_change_i,
    input  wire logic                          remote_id_found_i,
    output logic                               capture_done_o,
    output logic                               use_remote_id_o,
    output logic                               use_local_id_o,
    output logic                               use_internal_id_o,
    output logic [7:0]                         remote_id_addr_o,
    output logic                               copy_remote_id_o,
    output logic                               aux_audio_enable_o,
    output logic                               external_control_o,
    output logic                               coaxial_mode_o,
    output logic                               pll_reset_o
);
    // Strap levels come from an analog resolver: two flops before use
    logic [FIRST_LEVEL_WIDTH-1:0]  first_meta;
    logic [FIRST_LEVEL_WIDTH-1:0]  first_sync;
    logic [SECOND_LEVEL_WIDTH-1:0] second_meta;
    logic [SECOND_LEVEL_WIDTH-1:0] second_sync;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            first_meta  <= '0;
            first_sync  <= '0;
            second_meta <= '0;
            second_sync <= '0;
        end else begin
            first_meta  <= strap_level_first_i;
            first_sync  <= first_meta;
            second_meta <= strap_level_second_i;
            second_sync <= second_meta;
        end
    end

    logic dec_source;
    logic dec_aux;
    logic dec_override;
    logic dec_coaxial;
    logic dec_copy;

    strap_decoder u_strap_decoder (
        .strap_level_first_i   (first_sync),
        .strap_level_second_i  (second_sync),
        .display_id_source_o   (dec_source),
        .aux_audio_o           (dec_aux),
        .controller_override_o (dec_override),
        .cable_is_coaxial_o    (dec_coaxial),
        .remote_id_copy_o      (dec_copy)
    );

    // Wait two cycles after release so the synchroniser holds the strap
    capture_state_type state;
    capture_state_type next_state;
    logic              wait_count;

    always_comb begin
        case (state)
            CAPTURE_WAIT: next_state = wait_count ? CAPTURE_TAKE
                                                  : CAPTURE_WAIT;
            CAPTURE_TAKE: next_state = CAPTURE_DONE;
            CAPTURE_DONE: next_state = CAPTURE_DONE;
            default:      next_state = CAPTURE_WAIT;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state      <= CAPTURE_WAIT;
            wait_count <= 1'b0;
        end else begin
            state      <= next_state;
            wait_count <= 1'b1;
        end
    end

    wire take_strap = (state == CAPTURE_TAKE); // R22

    wire sel_control = (reg_addr_i == BRIDGE_CONTROL_OFFSET);
    wire sel_config  = (reg_addr_i == BRIDGE_CONFIG_OFFSET);
    wire sel_link    = (reg_addr_i == LINK_CONTROL_OFFSET);
    wire sel_rid     = (reg_addr_i == REMOTE_ID_ADDR_OFFSET);
    wire sel_any     = sel_control | sel_config | sel_link | sel_rid;

    wire wr_control = reg_write_i & sel_control;
    wire wr_config  = reg_write_i & sel_config;
    wire wr_link    = reg_write_i & sel_link;
    wire wr_rid     = reg_write_i & sel_rid;

    logic [7:0] bridge_control_reg;
    logic [7:0] bridge_config_reg;
    logic [7:0] link_control_one_reg;
    logic [7:0] remote_id_addr_reg;

    // Software write after capture replaces the strapped value
    function automatic logic [7:0] merge_bit(input logic [7:0] cur,
                                             input int pos,
                                             input logic val);
        logic [7:0] res;
        res      = cur;
        res[pos] = val;
        return res;
    endfunction

    wire [7:0] strap_control = merge_bit(bridge_control_reg,
        DISPLAY_ID_DISABLE_POS, dec_source); // R11 R23
    wire [7:0] strap_config = merge_bit(merge_bit(merge_bit(
        bridge_config_reg,
        AUDIO_AUX_POS, dec_aux), // R12
        EXTERNAL_CONTROL_POS, dec_override), // R13
        REMOTE_ID_COPY_POS, dec_copy); // R15
    wire [7:0] strap_link = merge_bit(link_control_one_reg,
        COAXIAL_MODE_POS, dec_coaxial); // R14

    wire [7:0] next_control = take_strap ? strap_control
                            : wr_control ? reg_wdata_i
                            : bridge_control_reg; // R1 R2
    wire [7:0] next_config  = take_strap ? strap_config
                            : wr_config  ? reg_wdata_i
                            : bridge_config_reg; // R1 R2
    wire [7:0] next_link    = take_strap ? strap_link
                            : wr_link    ? reg_wdata_i
                            : link_control_one_reg; // R1 R2 R19

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bridge_control_reg   <= BRIDGE_CONTROL_RESET;
            bridge_config_reg    <= BRIDGE_CONFIG_RESET;
            link_control_one_reg <= LINK_CONTROL_RESET;
            remote_id_addr_reg   <= REMOTE_ID_ADDR_RESET;
        end else begin
            bridge_control_reg   <= next_control;
            bridge_config_reg    <= next_config;
            link_control_one_reg <= next_link;
            if (wr_rid) begin
                remote_id_addr_reg <= reg_wdata_i; // R5
            end
        end
    end

    wire [7:0] read_mux = sel_control ? bridge_control_reg
                        : sel_config  ? bridge_config_reg
                        : sel_link    ? link_control_one_reg
                        : sel_rid     ? remote_id_addr_reg
                        : 8'h00; // R2

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_read_i) begin
            reg_rdata_o <= read_mux;
        end
    end

    assign reg_hit_o = sel_any & (reg_read_i | reg_write_i);

    // Mode outputs follow the registers, so a write steers them
    wire id_source = bridge_control_reg[DISPLAY_ID_DISABLE_POS];
    wire pll_feat  = link_control_one_reg[PLL_RESET_FREQ_POS];

    assign capture_done_o     = (state == CAPTURE_DONE);
    assign use_local_id_o     = id_source; // R6
    assign use_remote_id_o    = ~id_source & remote_id_found_i; // R5
    assign use_internal_id_o  = ~id_source & ~remote_id_found_i; // R5
    assign remote_id_addr_o   = remote_id_addr_reg; // R5
    assign copy_remote_id_o   = bridge_config_reg[REMOTE_ID_COPY_POS]
                              & remote_id_found_i; // R10
    assign aux_audio_enable_o = bridge_config_reg[AUDIO_AUX_POS]; // R7
    assign external_control_o =
        bridge_config_reg[EXTERNAL_CONTROL_POS]; // R8
    assign coaxial_mode_o     = link_control_one_reg[COAXIAL_MODE_POS]; // R9
    // Link runs single-lane; clock limits are the system's to keep
    assign pll_reset_o        = pll_feat & freq_change_i; // R16 R18 R19

    // Set by the first capture pulse; a second pulse is a fault
    logic strap_taken;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            strap_taken <= 1'b0;
        end else if (take_strap) begin
            strap_taken <= 1'b1;
        end
    end

    // Strap capture: right bits, rest of 0x5B untouched, exactly once
    a_capture_fields: assert property ( // R11 R13
        @(posedge clock_i) disable iff (rst_i)
        take_strap |=> bridge_control_reg[0] == $past(first_sync[1])
        && bridge_config_reg[7] == $past(second_sync[2]))
        else $error("Strap capture mismatch");
    a_config_capture: assert property ( // R12 R15
        @(posedge clock_i) disable iff (rst_i)
        take_strap |=> bridge_config_reg[1] == $past(first_sync[0])
        && bridge_config_reg[5] == $past(second_sync[0]))
        else $error("Config capture mismatch");
    a_link_capture: assert property ( // R14 R23
        @(posedge clock_i) disable iff (rst_i)
        take_strap |=> link_control_one_reg[7] == $past(second_sync[1])
        && link_control_one_reg[6:0] == $past(link_control_one_reg[6:0]))
        else $error("Link capture mismatch");
    a_capture_once: assert property ( // R22
        @(posedge clock_i) disable iff (rst_i)
        capture_done_o |=> !take_strap && capture_done_o)
        else $error("Second capture");
    a_single_take: assert property ( // R22
        @(posedge clock_i) disable iff (rst_i)
        take_strap |-> !strap_taken)
        else $error("Strap captured twice");
    a_capture_time: assert property ( // R1
        @(posedge clock_i) disable iff (rst_i)
        $rose(wait_count) |-> ##1 take_strap ##1 capture_done_o)
        else $error("Capture timing wrong");
    a_fields_hold: assert property ( // R22
        @(posedge clock_i) disable iff (rst_i)
        capture_done_o && !reg_write_i
        |=> $stable(bridge_control_reg) && $stable(bridge_config_reg)
        && $stable(link_control_one_reg))
        else $error("Field moved without a write");

    // Register port: writes land, reads return the addressed register
    a_write_takes: assert property ( // R2
        @(posedge clock_i) disable iff (rst_i)
        wr_config && !take_strap |=> bridge_config_reg == $past(reg_wdata_i))
        else $error("Write not stored");
    a_write_control: assert property ( // R2
        @(posedge clock_i) disable iff (rst_i)
        wr_control && !take_strap
        |=> bridge_control_reg == $past(reg_wdata_i))
        else $error("Control write not stored");
    a_write_link: assert property ( // R2 R19
        @(posedge clock_i) disable iff (rst_i)
        wr_link && !take_strap
        |=> link_control_one_reg == $past(reg_wdata_i))
        else $error("Link write not stored");
    a_write_address: assert property ( // R5
        @(posedge clock_i) disable iff (rst_i)
        wr_rid |=> remote_id_addr_o == $past(reg_wdata_i))
        else $error("Remote address write not stored");
    a_write_ignored: assert property ( // R2
        @(posedge clock_i) disable iff (rst_i)
        reg_write_i && !sel_any && !take_strap
        |=> $stable(bridge_control_reg) && $stable(bridge_config_reg)
        && $stable(link_control_one_reg) && $stable(remote_id_addr_reg))
        else $error("Unmapped write changed a register");
    a_read_control: assert property ( // R2
        @(posedge clock_i) disable iff (rst_i)
        reg_read_i && sel_control
        |=> reg_rdata_o == $past(bridge_control_reg))
        else $error("Control read wrong");
    a_read_config: assert property ( // R2
        @(posedge clock_i) disable iff (rst_i)
        reg_read_i && sel_config
        |=> reg_rdata_o == $past(bridge_config_reg))
        else $error("Config read wrong");
    a_read_link: assert property ( // R2
        @(posedge clock_i) disable iff (rst_i)
        reg_read_i && sel_link
        |=> reg_rdata_o == $past(link_control_one_reg))
        else $error("Link read wrong");
    a_read_unmapped: assert property ( // R2
        @(posedge clock_i) disable iff (rst_i)
        reg_read_i && !sel_any |=> reg_rdata_o == 8'h00)
        else $error("Unmapped read not zero");
    a_read_holds: assert property ( // R2
        @(posedge clock_i) disable iff (rst_i)
        !reg_read_i |=> $stable(reg_rdata_o))
        else $error("Read data moved without a read");

    // Mode outputs
    a_pll_blocked: assert property ( // R19
        @(posedge clock_i) disable iff (rst_i)
        !link_control_one_reg[5] |-> !pll_reset_o)
        else $error("PLL reset while disabled");
    a_pll_fires: assert property ( // R18
        @(posedge clock_i) disable iff (rst_i)
        link_control_one_reg[5] && freq_change_i |-> pll_reset_o)
        else $error("PLL reset missing");
    a_id_select: assert property ( // R5 R6
        @(posedge clock_i) disable iff (rst_i)
        $onehot({use_local_id_o, use_remote_id_o, use_internal_id_o}))
        else $error("Display-ID select not one-hot");
    a_remote_search: assert property ( // R5
        @(posedge clock_i) disable iff (rst_i)
        !bridge_control_reg[0] |-> use_remote_id_o == remote_id_found_i)
        else $error("Remote display-ID search wrong");
    a_copy_gate: assert property ( // R10
        @(posedge clock_i) disable iff (rst_i)
        !remote_id_found_i |-> !copy_remote_id_o)
        else $error("Copy without remote display-ID");

    c_capture:  cover property (@(posedge clock_i) disable iff (rst_i)
        take_strap ##1 capture_done_o);
    c_override: cover property (@(posedge clock_i) disable iff (rst_i)
        capture_done_o && wr_link);
    c_pll_off:  cover property (@(posedge clock_i) disable iff (rst_i)
        $fell(link_control_one_reg[5]));
    c_rid_write: cover property (@(posedge clock_i) disable iff (rst_i)
        capture_done_o && wr_rid);
    c_remote_copy: cover property (@(posedge clock_i) disable iff (rst_i)
        use_remote_id_o && copy_remote_id_o);
endmodule // strap_mode_config_latch

// File: test/strap_board_model.sv
// Board strap dividers, already resolved to level indices.
// Assumes the bench picks the divider position before each power-up.
`timescale 1ns/10ps
module strap_board_model
    import strap_cfg_pkg::*;
(
    input  wire logic [FIRST_LEVEL_WIDTH-1:0]  first_pick_i,
    input  wire logic [SECOND_LEVEL_WIDTH-1:0] second_pick_i,
    output logic [FIRST_LEVEL_WIDTH-1:0]       strap_level_first_o,
    output logic [SECOND_LEVEL_WIDTH-1:0]      strap_level_second_o
);
    // Static dividers: the index follows the fitted resistor pair
    assign strap_level_first_o  = first_pick_i;
    assign strap_level_second_o = second_pick_i;
endmodule // strap_board_model

// File: test/strap_mode_config_latch_tb.sv
// Self-checking bench for the strap configuration latch.
// Assumes the board model feeds the straps; the bench acts as host.
`timescale 1ns/10ps
module strap_mode_config_latch_tb
    import strap_cfg_pkg::*;
;
    logic       clock_i = 0, rst_i = 1, reg_write_i = 0, reg_read_i = 0;
    logic       freq_change_i = 0, found = 0, rd_seen = 0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, d;
    logic [1:0] first_pick = 2'h0;
    logic [2:0] second_pick = 3'h0;
    wire  [1:0] lvl_first;
    wire  [2:0] lvl_second;
    logic [7:0] reg_rdata_o, remote_id_addr_o, exp_q[$];
    logic       reg_hit_o, capture_done_o, use_remote_id_o, use_local_id_o;
    logic       use_internal_id_o, copy_remote_id_o, aux_audio_enable_o;
    logic       external_control_o, coaxial_mode_o, pll_reset_o;
    int         err_count = 0, comparisons = 0;

    // Bench clock stays well under the older receivers' pixel limit
    always #12.5 clock_i = ~clock_i;

    strap_board_model u_strap_board_model (
        .first_pick_i(first_pick), .second_pick_i(second_pick),
        .strap_level_first_o(lvl_first), .strap_level_second_o(lvl_second));

    strap_mode_config_latch u_strap_mode_config_latch (
        .clock_i(clock_i), .rst_i(rst_i),
        .strap_level_first_i(lvl_first), .strap_level_second_i(lvl_second),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
        .freq_change_i(freq_change_i), .remote_id_found_i(found),
        .capture_done_o(capture_done_o), .use_remote_id_o(use_remote_id_o),
        .use_local_id_o(use_local_id_o),
        .use_internal_id_o(use_internal_id_o),
        .remote_id_addr_o(remote_id_addr_o),
        .copy_remote_id_o(copy_remote_id_o),
        .aux_audio_enable_o(aux_audio_enable_o),
        .external_control_o(external_control_o),
        .coaxial_mode_o(coaxial_mode_o), .pll_reset_o(pll_reset_o));

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task results;
        $display("Compared %0d, mismatched %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock_i);
        reg_write_i = 1;
        reg_addr_i  = a;
        reg_wdata_i = v;
        @(negedge clock_i);
        reg_write_i = 0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] v, input logic hit);
        @(negedge clock_i);
        reg_read_i = 1;
        reg_addr_i = a;
        exp_q.push_back(v);
        #1 check("hit", 8'(reg_hit_o), 8'(hit));
        @(negedge clock_i);
        reg_read_i = 0;
    endtask

    // Straps must already be stable when reset lets go
    task pu(input logic [1:0] f, input logic [2:0] s);
        @(negedge clock_i);
        rst_i       = 1;
        first_pick  = f;
        second_pick = s;
        repeat (5) @(negedge clock_i);
        rst_i = 0;
        repeat (2) @(negedge clock_i);
        check("early", 8'(capture_done_o), 8'h00);
        @(negedge clock_i);
        check("done", 8'(capture_done_o), 8'h01);
    endtask

    // Read data lands on the same edge that takes the strobe
    always @(posedge clock_i) rd_seen <= reg_read_i;
    always @(negedge clock_i) begin
        if (rd_seen)
            check("rdata", reg_rdata_o, exp_q.pop_front());
    end

    initial begin
        #100_000;
        err_count++;
        results();
    end

    initial begin
        logic [1:0] f;
        logic [2:0] s;
        void'($urandom(32'hf051_9da3));
        for (int i = 0; i < 8; i++) begin
            f = i[1:0];
            s = i[2:0];
            pu(f, s);
            // Late strap movement must not reach the fields
            found       = 1'($urandom_range(1));
            first_pick  = 2'($urandom);
            second_pick = 3'($urandom);
            rd(BRIDGE_CONTROL_OFFSET, {7'h0, f[1]}, 1);
            rd(BRIDGE_CONFIG_OFFSET, {s[2], 1'b0, s[0], 3'h0, f[0], 1'b0},
               1);
            rd(LINK_CONTROL_OFFSET, {s[1], 7'h20}, 1);
            rd(REMOTE_ID_ADDR_OFFSET, 8'hA0, 1);
            check("aux", 8'(aux_audio_enable_o), 8'(f[0]));
            check("ext", 8'(external_control_o), 8'(s[2]));
            check("coaxial", 8'(coaxial_mode_o), 8'(s[1]));
            check("copy", 8'(copy_remote_id_o), 8'(s[0] & found));
            check("source", 8'({use_local_id_o, use_remote_id_o,
                  use_internal_id_o}),
                  f[1] ? 8'h04 : (found ? 8'h02 : 8'h01));
            check("addr", remote_id_addr_o, 8'hA0);
            d = 8'($urandom);
            wr(BRIDGE_CONFIG_OFFSET, d);
            rd(BRIDGE_CONFIG_OFFSET, d, 1);
            check("aux wr", 8'(aux_audio_enable_o), 8'(d[1]));
            wr(BRIDGE_CONTROL_OFFSET, ~d);
            rd(BRIDGE_CONTROL_OFFSET, ~d, 1);
            wr(8'h30, d);
            rd(8'h30, 8'h00, 0);
            wr(REMOTE_ID_ADDR_OFFSET, ~d);
            check("addr wr", remote_id_addr_o, ~d);
            rd(REMOTE_ID_ADDR_OFFSET, ~d, 1);
            // Keeps the PLL-reset feature on for the closing check
            wr(LINK_CONTROL_OFFSET, {d[7], 7'h20});
            check("coaxial wr", 8'(coaxial_mode_o), 8'(d[7]));
        end
        freq_change_i = 1;
        #1 check("pll on", 8'(pll_reset_o), 8'h01);
        // Disable goes last, after all other configuration
        wr(LINK_CONTROL_OFFSET, 8'h00);
        check("pll off", 8'(pll_reset_o), 8'h00);
        rd(LINK_CONTROL_OFFSET, 8'h00, 1);
        repeat (2) @(negedge clock_i);
        results();
    end
endmodule // strap_mode_config_latch_tb
